//--- rtl/midi_mixer_remote_decoder.sv
// Decoder of remote MIDI messages into mixer actions, with feedback and loop guard
`timescale 1ns/1ps
`default_nettype none
module midi_mixer_remote_decoder
  import remote_decoder_pkg::*;
#(
  parameter int unsigned MARKER_CYCLES = MARKER_PERIOD_CYC,
  parameter int unsigned COLUMNS = 64
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic enable_set,
  input wire logic surface_protocol,
  input wire logic tx_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output remote_decoder_pkg::mixer_action_t action,
  output logic action_valid,
  output remote_decoder_pkg::toggle_state_t toggles,
  output logic remote_enable,
  output logic loop_detected,
  output logic [1:0] window_row,
  output logic [5:0] window_col,
  output logic submix_view,
  output logic [4:0] gain_in1,
  output logic [4:0] gain_in2,
  output logic gain_invalid
);
  import remote_decoder_pkg::*;

  initial begin
    if (COLUMNS < 8 || COLUMNS > 64) $error("COLUMNS must be 8..64");
    if (MARKER_CYCLES < 2) $error("MARKER_CYCLES too small");
  end

  // ==========================================================
  // Message assembly
  logic [3:0] status_r;
  logic [3:0] chan_r;
  logic [6:0] data1_r;
  logic have_status_r;
  logic have_d1_r;
  logic msg_done;
  logic [6:0] data2;

  assign data2 = rx_byte[6:0];
  assign msg_done = rx_valid && !rx_byte[7] && have_status_r && have_d1_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_r <= 4'h0;
      chan_r <= 4'h0;
      data1_r <= 7'h00;
      have_status_r <= 1'b0;
      have_d1_r <= 1'b0;
    end else if (rx_valid) begin
      if (rx_byte[7]) begin
        // Running status kept; system bytes drop the message
        status_r <= rx_byte[7:4];
        chan_r <= rx_byte[3:0];
        have_status_r <= rx_byte[7:4] != 4'hF;
        have_d1_r <= 1'b0;
      end else if (have_status_r && !have_d1_r) begin
        data1_r <= rx_byte[6:0];
        have_d1_r <= 1'b1;
      end else begin
        have_d1_r <= 1'b0;
      end
    end
  end

  logic is_note_on;
  logic is_note;
  logic is_cc;
  logic is_pitch;
  assign is_note = status_r == ST_NOTE_ON || status_r == ST_NOTE_OFF;
  assign is_note_on = status_r == ST_NOTE_ON && data2 != 7'h00;
  assign is_cc = status_r == ST_CTRL;
  assign is_pitch = status_r == ST_PITCH;

  // ==========================================================
  // Loop guard
  logic [31:0] marker_cnt_r;
  logic marker_due_r;
  logic loop_hit;
  assign loop_hit = msg_done && is_note_on && chan_r == CH_1 && data1_r == NOTE_LOOP_MARKER;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      marker_cnt_r <= 32'h0;
    end else if (marker_cnt_r == MARKER_CYCLES - 1) begin
      marker_cnt_r <= 32'h0;
    end else begin
      marker_cnt_r <= marker_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      remote_enable <= 1'b0;
      loop_detected <= 1'b0;
    end else begin
      // loop wins over enable in same cycle
      if (loop_hit) begin
        remote_enable <= 1'b0;
        loop_detected <= 1'b1;
      end else if (enable_set) begin
        remote_enable <= 1'b1;
        loop_detected <= 1'b0;
      end
    end
  end

  logic act;
  assign act = msg_done && remote_enable && !loop_hit;

  // ==========================================================
  // Decode
  mixer_action_t dec;
  logic dec_toggle;
  logic [7:0] tog_mask;
  logic [6:0] strip_col;

  always_comb begin
    dec = '{kind: ACT_NONE, row: ROW_INPUT, index: 6'h00, value: data2};
    dec_toggle = 1'b0;
    tog_mask = 8'h00;
    strip_col = 7'(window_col) + 7'(data1_r[2:0]);
    if (is_cc) begin
      if (chan_r == CH_1 && data1_r == CC_VOLUME) begin
        dec.kind = ACT_MAIN_VOL;
      end else if (data1_r == CC_PREAMP_GAIN && chan_r[3:1] == 3'h0) begin
        dec.kind = ACT_GAIN;
        dec.index = {5'h00, chan_r[0]};
      end else if (chan_r == CH_13 && data1_r >= CC_SUBMIX_FIRST && data1_r <= CC_FADER_LAST) begin
        dec.kind = ACT_SUBMIX;
        dec.row = ROW_OUTPUT;
        dec.index = 6'(data1_r - CC_SUBMIX_FIRST);
      end else if (chan_r == CH_13 && data1_r == CC_TRIM) begin
        dec.kind = ACT_TOGGLE;
        dec_toggle = 1'b1;
        tog_mask = 8'h04;
      end else if (chan_r < CH_13 && data1_r >= CC_FADER_FIRST && data1_r <= CC_FADER_LAST) begin
        dec.kind = ACT_FADER;
        dec.row = row_t'(chan_r[3:2]);
        // channel offset picks group of sixteen
        dec.index = {chan_r[1:0], 4'(data1_r - CC_FADER_FIRST)};
        // 68 unity, 7F max, 0 off, passed raw
        dec.value = data2;
      end
    end else if (is_pitch && chan_r == MASTER_STRIP) begin
      dec.kind = ACT_MAIN_VOL;
      dec.value = data2;
    end else if (is_note_on && chan_r == CH_1) begin
      case (data1_r)
        NOTE_DIM: tog_mask = 8'h80;
        NOTE_MONO: tog_mask = 8'h40;
        NOTE_TALKBACK: tog_mask = 8'h20;
        NOTE_RECALL: tog_mask = 8'h10;
        NOTE_SPEAKER_B: tog_mask = 8'h08;
        NOTE_TRIM: tog_mask = 8'h04;
        NOTE_MASTER_MUTE: tog_mask = 8'h02;
        NOTE_MASTER_SOLO: tog_mask = 8'h01;
        default: tog_mask = 8'h00;
      endcase
      if (tog_mask != 8'h00) begin
        dec.kind = ACT_TOGGLE;
        dec_toggle = 1'b1;
      end else if (data1_r >= NOTE_CUE_MAIN && data1_r <= NOTE_CUE_PH2) begin
        dec.kind = ACT_CUE;
        dec.index = 6'(data1_r - NOTE_CUE_MAIN);
      end else if (data1_r >= NOTE_SNAP_FIRST && data1_r <= NOTE_SNAP_LAST) begin
        dec.kind = ACT_SNAPSHOT;
        dec.index = 6'(data1_r - NOTE_SNAP_KEY_FIRST);
      end else if (data1_r <= NOTE_BUS_BTN_LAST) begin
        dec.kind = ACT_SUBMIX;
        dec.row = ROW_OUTPUT;
        dec.index = strip_col[5:0];
      end
    end
  end

  // ==========================================================
  // Action output
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      action <= '{kind: ACT_NONE, row: ROW_INPUT, index: 6'h00, value: 7'h00};
      action_valid <= 1'b0;
    end else if (act && dec.kind != ACT_NONE) begin
      action <= dec;
      action_valid <= 1'b1;
    end else begin
      action_valid <= 1'b0;
    end
  end

  // Toggle state; submix selection also leaves trim
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      toggles <= '0;
    end else if (act && dec_toggle) begin
      toggles <= toggles ^ tog_mask;
    end else if (act && dec.kind == ACT_SUBMIX) begin
      toggles.trim_mode <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gain_in1 <= 5'h00;
      gain_in2 <= 5'h00;
      gain_invalid <= 1'b0;
    end else if (act && dec.kind == ACT_GAIN) begin
      gain_invalid <= (data2 > GAIN_MAX_DB) || (data2 % GAIN_STEP_DB != 7'h00);
      if (data2 <= GAIN_MAX_DB && data2 % GAIN_STEP_DB == 7'h00) begin
        // Five bits: 60 dB is step 20
        if (dec.index[0]) gain_in2 <= 5'(data2 / GAIN_STEP_DB);
        else gain_in1 <= 5'(data2 / GAIN_STEP_DB);
      end
    end
  end

  // ==========================================================
  // Fader window
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      window_row <= ROW_INPUT;
      window_col <= 6'h00;
      submix_view <= 1'b1;
    end else if (act && is_note_on && chan_r == CH_1) begin
      case (data1_r)
        NOTE_CH_LEFT: if (window_col != 6'h00) window_col <= window_col - 6'h01;
        NOTE_CH_RIGHT: if (window_col < 6'(COLUMNS - 8)) window_col <= window_col + 6'h01;
        NOTE_BANK_LEFT: window_col <= (window_col < 6'h08) ? 6'h00 : window_col - 6'h08;
        NOTE_BANK_RIGHT: begin
          // Seven bits so the sum cannot wrap
          if ({1'b0, window_col} + 7'h08 <= 7'(COLUMNS - 8)) window_col <= window_col + 6'h08;
        end
        NOTE_ROW_UP: if (window_row != ROW_INPUT) window_row <= window_row - 2'h1;
        NOTE_ROW_DOWN: if (window_row != ROW_OUTPUT) window_row <= window_row + 2'h1;
        default: window_row <= window_row;
      endcase
    end
  end

  // ==========================================================
  // Output: marker note and feedback echo
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_B1 = 2'b01, TX_B2 = 2'b11, TX_B3 = 2'b10
  } tx_state_t;
  tx_state_t tx_state_r;
  logic [7:0] tx_b0_r;
  logic [7:0] tx_b1_r;
  logic [7:0] tx_b2_r;
  logic echo_pend_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      marker_due_r <= 1'b0;
    end else if (marker_cnt_r == MARKER_CYCLES - 1) begin
      marker_due_r <= 1'b1;
    end else if (tx_state_r == TX_IDLE && marker_due_r) begin
      marker_due_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      echo_pend_r <= 1'b0;
      tx_b0_r <= 8'h00;
      tx_b1_r <= 8'h00;
      tx_b2_r <= 8'h00;
    // echo while surface protocol in use
    end else if (act && surface_protocol && !echo_pend_r) begin
      echo_pend_r <= 1'b1;
      tx_b0_r <= {status_r, chan_r};
      tx_b1_r <= {1'b0, data1_r};
      tx_b2_r <= {1'b0, data2};
    end else if (tx_state_r == TX_IDLE && !marker_due_r && echo_pend_r) begin
      echo_pend_r <= 1'b0;
    end
  end

  logic [7:0] mk_b1;
  logic [7:0] mk_b2;
  logic sending_marker_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_state_r <= TX_IDLE;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      sending_marker_r <= 1'b0;
      mk_b1 <= 8'h00;
      mk_b2 <= 8'h00;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          if (marker_due_r) begin
            tx_byte <= {ST_NOTE_ON, CH_1};
            tx_valid <= 1'b1;
            mk_b1 <= {1'b0, NOTE_LOOP_MARKER};
            mk_b2 <= {1'b0, MARKER_VELOCITY};
            sending_marker_r <= 1'b1;
            tx_state_r <= TX_B1;
          end else if (echo_pend_r) begin
            tx_byte <= tx_b0_r;
            tx_valid <= 1'b1;
            mk_b1 <= tx_b1_r;
            mk_b2 <= tx_b2_r;
            sending_marker_r <= 1'b0;
            tx_state_r <= TX_B1;
          end
        end
        TX_B1: if (tx_ready) begin
          tx_byte <= mk_b1;
          tx_state_r <= TX_B2;
        end
        TX_B2: if (tx_ready) begin
          tx_byte <= mk_b2;
          tx_state_r <= TX_B3;
        end
        // State, not byte value, ends the message: equal data bytes are legal
        TX_B3: if (tx_ready) begin
          tx_valid <= 1'b0;
          tx_state_r <= TX_IDLE;
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  // nothing acts while disabled
  disabled_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
    msg_done && !remote_enable |=> !action_valid) else $error("action while disabled");
  loop_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    loop_hit |=> !remote_enable && loop_detected) else $error("loop not caught");
  main_volume_a: assert property (@(posedge clk_sys) disable iff (srst)
    act && is_cc && chan_r == CH_1 && data1_r == CC_VOLUME
    |=> action_valid && action.kind == ACT_MAIN_VOL && action.value == $past(data2))
    else $error("main volume missed");
  fader_row_a: assert property (@(posedge clk_sys) disable iff (srst)
    act && is_cc && chan_r == 4'h4 && data1_r == CC_FADER_FIRST
    |=> action.kind == ACT_FADER && action.row == ROW_PLAYBACK && action.index == 6'h00)
    else $error("fader row wrong");
  fader_index_a: assert property (@(posedge clk_sys) disable iff (srst)
    act && is_cc && chan_r == 4'h1 && data1_r == CC_FADER_LAST
    |=> action.index == 6'h1F) else $error("fader index wrong");
  dim_toggle_a: assert property (@(posedge clk_sys) disable iff (srst)
    act && is_note_on && chan_r == CH_1 && data1_r == NOTE_DIM
    |=> toggles.dim != $past(toggles.dim)) else $error("dim not toggled");
  snapshot_idx_a: assert property (@(posedge clk_sys) disable iff (srst)
    act && is_note_on && chan_r == CH_1 && data1_r == NOTE_SNAP_LAST
    |=> action.kind == ACT_SNAPSHOT && action.index == 6'h07) else $error("snapshot wrong");
  gain_step_a: assert property (@(posedge clk_sys) disable iff (srst)
    act && dec.kind == ACT_GAIN && data2 == 7'h0B |=> gain_invalid)
    else $error("gain step not flagged");
  unknown_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
    act && dec.kind == ACT_NONE |=> !action_valid && toggles == $past(toggles))
    else $error("unknown message changed state");
  marker_sent_a: assert property (@(posedge clk_sys) disable iff (srst)
    marker_due_r && tx_state_r == TX_IDLE |=> tx_valid && tx_byte == {ST_NOTE_ON, CH_1})
    else $error("marker not sent");
  fader_seen_c: cover property (@(posedge clk_sys) action_valid && action.kind == ACT_FADER);
  loop_seen_c: cover property (@(posedge clk_sys) loop_hit);
  echo_seen_c: cover property (@(posedge clk_sys) tx_valid && !sending_marker_r);
endmodule
`default_nettype wire

//--- rtl/remote_decoder_pkg.sv
// Package with constants and carrier types for the remote MIDI decoder
package remote_decoder_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned MARKER_PERIOD_MS = 500;
  localparam int unsigned MARKER_PERIOD_CYC = (CLK_HZ / 1000) * MARKER_PERIOD_MS;
  // ==========================================================
  // Message codes
  localparam logic [3:0] ST_NOTE_OFF = 4'h8;
  localparam logic [3:0] ST_NOTE_ON = 4'h9;
  localparam logic [3:0] ST_CTRL = 4'hB;
  localparam logic [3:0] CH_1 = 4'h0;
  localparam logic [3:0] CH_13 = 4'hC;
  localparam logic [6:0] CC_VOLUME = 7'h07;
  localparam logic [6:0] CC_PREAMP_GAIN = 7'h09;
  localparam logic [6:0] CC_FADER_FIRST = 7'h66;
  localparam logic [6:0] CC_FADER_LAST = 7'h75;
  localparam logic [6:0] CC_TRIM = 7'h66;
  localparam logic [6:0] CC_SUBMIX_FIRST = 7'h68;
  localparam logic [6:0] GAIN_MAX_DB = 7'h3C;
  localparam logic [6:0] GAIN_STEP_DB = 7'h03;
  localparam logic [6:0] FADER_UNITY = 7'h68;
  localparam logic [6:0] FADER_MAX = 7'h7F;
  // ==========================================================
  // Note assignments
  localparam logic [6:0] NOTE_DIM = 7'h5D;
  localparam logic [6:0] NOTE_MONO = 7'h2A;
  localparam logic [6:0] NOTE_TALKBACK = 7'h5E;
  localparam logic [6:0] NOTE_RECALL = 7'h5F;
  localparam logic [6:0] NOTE_SPEAKER_B = 7'h32;
  localparam logic [6:0] NOTE_CUE_MAIN = 7'h3E;
  localparam logic [6:0] NOTE_CUE_PH1 = 7'h3F;
  localparam logic [6:0] NOTE_CUE_PH2 = 7'h40;
  localparam logic [6:0] NOTE_SNAP_FIRST = 7'h36;
  localparam logic [6:0] NOTE_SNAP_LAST = 7'h3D;
  localparam logic [6:0] NOTE_TRIM = 7'h2D;
  localparam logic [6:0] NOTE_MASTER_MUTE = 7'h2C;
  localparam logic [6:0] NOTE_MASTER_SOLO = 7'h2B;
  localparam logic [6:0] NOTE_LOOP_MARKER = 7'h7E;
  localparam logic [6:0] MARKER_VELOCITY = 7'h7F;
  // ==========================================================
  // Surface buttons
  localparam logic [6:0] NOTE_SNAP_KEY_FIRST = 7'h36;
  localparam logic [6:0] NOTE_CH_LEFT = 7'h30;
  localparam logic [6:0] NOTE_CH_RIGHT = 7'h31;
  localparam logic [6:0] NOTE_BANK_LEFT = 7'h2E;
  localparam logic [6:0] NOTE_BANK_RIGHT = 7'h2F;
  localparam logic [6:0] NOTE_ROW_UP = 7'h60;
  localparam logic [6:0] NOTE_ROW_DOWN = 7'h61;
  localparam logic [6:0] NOTE_BUS_BTN_FIRST = 7'h00;
  localparam logic [6:0] NOTE_BUS_BTN_LAST = 7'h07;
  localparam logic [3:0] ST_PITCH = 4'hE;
  localparam logic [3:0] MASTER_STRIP = 4'h8;
  // ==========================================================
  // Action kinds
  typedef enum logic [3:0] {
    ACT_NONE = 4'h0, ACT_FADER = 4'h1, ACT_MAIN_VOL = 4'h2, ACT_GAIN = 4'h3,
    ACT_SNAPSHOT = 4'h4, ACT_CUE = 4'h5, ACT_SUBMIX = 4'h6, ACT_TOGGLE = 4'h7
  } action_kind_t;
  typedef enum logic [1:0] {ROW_INPUT = 2'h0, ROW_PLAYBACK = 2'h1, ROW_OUTPUT = 2'h2} row_t;
  typedef struct packed {
    action_kind_t kind;
    row_t row;
    logic [5:0] index;
    logic [6:0] value;
  } mixer_action_t;
  typedef struct packed {
    logic dim;
    logic mono;
    logic talkback;
    logic recall;
    logic speaker_b;
    logic trim_mode;
    logic master_mute;
    logic master_solo;
  } toggle_state_t;
endpackage

//--- tb/midi_mixer_remote_decoder_tb.sv
// Self-checking bench for the remote MIDI decoder
`timescale 1ns/1ps
`default_nettype none
module midi_mixer_remote_decoder_tb;
  import remote_decoder_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic enable_set = 1'b0;
  logic surface_protocol = 1'b0;
  logic stall = 1'b0;
  logic loop_back = 1'b0;
  logic [7:0] rx_byte, tx_byte;
  logic rx_valid, tx_ready, tx_valid, action_valid, remote_enable, loop_detected;
  logic submix_view, gain_invalid;
  logic [1:0] window_row;
  logic [5:0] window_col;
  logic [4:0] gain_in1, gain_in2;
  logic [23:0] last_msg;
  int marker_cnt;
  mixer_action_t action, last_act;
  toggle_state_t toggles;
  int act_cnt = 0;
  int mismatches = 0;
  int compares = 0;
  always #4 clk_sys = ~clk_sys;
  // Short marker period keeps the loop test brief
  midi_mixer_remote_decoder #(.MARKER_CYCLES(200), .COLUMNS(64)) dut (
    .clk_sys(clk_sys), .srst(srst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .enable_set(enable_set), .surface_protocol(surface_protocol), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .action(action), .action_valid(action_valid),
    .toggles(toggles), .remote_enable(remote_enable), .loop_detected(loop_detected),
    .window_row(window_row), .window_col(window_col), .submix_view(submix_view),
    .gain_in1(gain_in1), .gain_in2(gain_in2), .gain_invalid(gain_invalid));
  midi_surface_model surf (
    .clk_sys(clk_sys), .tx_byte(tx_byte), .tx_valid(tx_valid), .stall(stall),
    .loop_back(loop_back), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .last_msg(last_msg), .marker_cnt(marker_cnt));
  always @(posedge clk_sys) begin
    if (action_valid === 1'b1) begin
      last_act <= action;
      act_cnt <= act_cnt + 1;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic snd(input logic [23:0] m);
    surf.send(m);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic en();
    @(posedge clk_sys);
    enable_set <= 1'b1;
    @(posedge clk_sys);
    enable_set <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_disabled();
    chk(submix_view, 1'b1);
    snd(24'h905D7F);
    chk(toggles, 8'h00);
    chk(act_cnt, 0);
    en();
    chk(remote_enable, 1'b1);
    $display("test disabled done");
  endtask
  task automatic t_toggles();
    logic [6:0] nt [8] = '{7'h5D, 7'h2A, 7'h5E, 7'h5F, 7'h32, 7'h2D, 7'h2C, 7'h2B};
    logic [7:0] e = 8'h00;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        snd({8'h90, 1'b0, nt[i], 8'h7F});
        e = e ^ (8'h80 >> i);
        chk(toggles, e);
      end
      snd(24'h805D40);
      chk(toggles, e);
    end
    snd(24'h90107F);
    chk(toggles, 8'h00);
    $display("test toggles done");
  endtask
  task automatic t_snap_cue();
    for (int n = 8'h36; n <= 8'h40; n++) begin
      snd({8'h90, n[7:0], 8'h7F});
      chk(last_act.kind, (n <= 8'h3D) ? ACT_SNAPSHOT : ACT_CUE);
    end
    $display("test snapshot cue done");
  endtask
  task automatic t_faders();
    logic [23:0] m [4] = '{24'hB06668, 24'hB16A00, 24'hB4667F, 24'hB86868};
    mixer_action_t e [4] = '{'{ACT_FADER, ROW_INPUT, 6'h00, 7'h68},
      '{ACT_FADER, ROW_INPUT, 6'h14, 7'h00}, '{ACT_FADER, ROW_PLAYBACK, 6'h00, 7'h7F},
      '{ACT_FADER, ROW_OUTPUT, 6'h02, 7'h68}};
    int c;
    for (int i = 0; i < 4; i++) begin
      snd(m[i]);
      chk(last_act, e[i]);
    end
    snd(24'hB00755);
    chk({last_act.kind, last_act.value}, {ACT_MAIN_VOL, 7'h55});
    snd(24'hE80050);
    chk({last_act.kind, last_act.value}, {ACT_MAIN_VOL, 7'h50});
    c = act_cnt;
    snd(24'hB02010);
    snd(24'hB06510);
    chk(act_cnt, c);
    $display("test faders done");
  endtask
  task automatic t_trim_gain();
    snd(24'hBC6600);
    chk(toggles.trim_mode, 1'b1);
    snd(24'hBC6900);
    chk(last_act.kind, ACT_SUBMIX);
    chk(toggles.trim_mode, 1'b0);
    snd(24'hB0090C);
    chk({gain_in1, gain_invalid}, {5'h04, 1'b0});
    snd(24'hB1092D);
    chk(gain_in2, 5'h0F);
    snd(24'hB0090B);
    chk({gain_in1, gain_invalid}, {5'h04, 1'b1});
    snd(24'hB0093F);
    chk({gain_in1, gain_invalid}, {5'h04, 1'b1});
    snd(24'hB2090C);
    chk({gain_in1, gain_in2}, {5'h04, 5'h0F});
    snd(24'hB0093C);
    chk({gain_in1, gain_invalid}, {5'h14, 1'b0});
    $display("test trim gain done");
  endtask
  task automatic t_window();
    logic [6:0] nt [4] = '{7'h31, 7'h2F, 7'h30, 7'h2E};
    logic [5:0] e [4] = '{6'h01, 6'h09, 6'h08, 6'h00};
    for (int i = 0; i < 4; i++) begin
      snd({8'h90, 1'b0, nt[i], 8'h7F});
      chk(window_col, e[i]);
    end
    snd(24'h90037F);
    chk(last_act, mixer_action_t'{ACT_SUBMIX, ROW_OUTPUT, 6'h03, 7'h7F});
    snd(24'h903D7F);
    chk(last_act, mixer_action_t'{ACT_SNAPSHOT, ROW_INPUT, 6'h07, 7'h7F});
    $display("test window done");
  endtask
  task automatic t_echo();
    surface_protocol <= 1'b1;
    stall <= 1'b1;
    snd(24'hB00721);
    repeat (10) @(posedge clk_sys);
    chk(tx_valid, 1'b1);
    stall <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk(last_msg, 24'hB00721);
    surface_protocol <= 1'b0;
    $display("test echo done");
  endtask
  task automatic t_loop();
    chk(marker_cnt > 0, 1'b1);
    loop_back <= 1'b1;
    for (int i = 0; i < 1000 && loop_detected !== 1'b1; i++) @(posedge clk_sys);
    #1;
    chk({loop_detected, remote_enable}, 2'b10);
    loop_back <= 1'b0;
    repeat (8) @(posedge clk_sys);
    snd(24'h905D7F);
    chk(toggles, 8'h00);
    en();
    chk({loop_detected, remote_enable}, 2'b01);
    $display("test loop done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_disabled();
    t_toggles();
    t_snap_cue();
    t_faders();
    t_trim_gain();
    t_window();
    t_echo();
    t_loop();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- tb/midi_surface_model.sv
// Behavioural control surface on the far side of the MIDI link
`timescale 1ns/1ps
`default_nettype none
module midi_surface_model (
  input wire logic clk_sys,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic stall,
  input wire logic loop_back,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic [23:0] last_msg,
  output int marker_cnt
);
  logic [23:0] acc = 24'h000000;
  logic lp = 1'b0;
  int n = 0;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    last_msg = 24'h000000;
    marker_cnt = 0;
  end
  // Stalling holds the device transmitter mid-message
  assign tx_ready = ~stall;
  // ==========================================================
  // Receive side of the surface, with an optional miswired loop
  always @(posedge clk_sys) begin
    lp <= loop_back && tx_valid && tx_ready;
    if (tx_valid && tx_ready) begin
      acc = {acc[15:0], tx_byte};
      n = (n == 2) ? 0 : n + 1;
      if (n == 0 && acc == 24'h907E7F) marker_cnt <= marker_cnt + 1;
      else if (n == 0) last_msg <= acc;
      if (loop_back) begin
        rx_byte <= tx_byte;
        rx_valid <= 1'b1;
      end
    end else if (lp) begin
      rx_valid <= 1'b0;
    end
  end
  // ==========================================================
  // zero-based channel nibble
  task automatic send(input logic [23:0] msg);
    for (int i = 2; i >= 0; i--) begin
      @(posedge clk_sys);
      rx_byte <= msg[i*8 +: 8];
      rx_valid <= 1'b1;
    end
    @(posedge clk_sys);
    rx_byte <= ~msg[7:0];
    rx_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire
